// *** verilog/tpwm_pkg.sv ***
// Package for the three-phase PWM control block: register map, fields, reset values.
// Assumes a 32-bit AXI4-Lite register bus and a single 100 MHz clock.
package tpwm_pkg;
   // ----------------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------------
   localparam logic [7:0] TPWM_MODE_OFS = 8'h00;
   localparam logic [7:0] TPWM_GENCTL_OFS = 8'h04;
   localparam logic [7:0] TPWM_PERIOD_OFS = 8'h08;
   localparam logic [7:0] TPWM_DUTYA_OFS = 8'h0C;
   localparam logic [7:0] TPWM_DUTYB_OFS = 8'h10;
   localparam logic [7:0] TPWM_DUTYC_OFS = 8'h14;
   localparam logic [7:0] TPWM_DEAD_OFS = 8'h18;
   localparam logic [7:0] TPWM_STATUS_OFS = 8'h1C;
   // ----------------------------------------------------------------------
   // Field positions and widths
   // ----------------------------------------------------------------------
   localparam int TPWM_CNT_W = 12;
   localparam int TPWM_DEAD_W = 8;
   localparam int TPWM_GEN_EN_BIT = 0;
   localparam int TPWM_SHAPE_LSB = 1;
   localparam int TPWM_HS_EN_LSB = 4;
   localparam int TPWM_LS_EN_LSB = 8;
   // ----------------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------------
   localparam logic [1:0] TPWM_MODE_RST = 2'h0;
   localparam logic [TPWM_CNT_W-1:0] TPWM_PERIOD_RST = 12'h3E8;
   localparam logic [TPWM_DEAD_W-1:0] TPWM_DEAD_RST = 8'h04;
   // AXI responses
   localparam logic [1:0] TPWM_RESP_OK = 2'h0;
   localparam logic [1:0] TPWM_RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {TPWM_SH_UPDN, TPWM_SH_UP, TPWM_SH_DOWN, TPWM_SH_RSV} tpwm_shape_t;
   typedef enum {TPWM_M_SIX, TPWM_M_THREE, TPWM_M_GEN} tpwm_mode_t;

   // One phase's drive: value and enable of the output pin
   typedef struct packed {
      logic drive;
      logic oe;
   } tpwm_pin_t;
endpackage

// *** verilog/tpwm_ctrl.sv ***
// Three-phase PWM control: input decode in 6x/3x modes, internal generator mode.
// Assumes synchronous inputs, one 100 MHz clock, software over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module tpwm_ctrl #(
   parameter int CNT_W = tpwm_pkg::TPWM_CNT_W,
   parameter int DEAD_W = tpwm_pkg::TPWM_DEAD_W,
   parameter bit STRAP_VARIANT = 1'b0
) (
   input wire logic ref_clk,
   input wire logic rst,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Command inputs and strap
   input wire logic [2:0] high_side_cmd_in,
   input wire logic [2:0] low_side_cmd_in,
   input wire logic sleep_n_in,
   input wire logic mode_strap_in,
   // Phase outputs: level and output enable
   output logic [2:0] phase_out,
   output logic [2:0] phase_oe,
   output logic sync_ref_out
);
   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic aw_hold;
      logic [7:0] awaddr;
      logic w_hold;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [1:0] mode_field;
      logic strap_mode;
      logic strap_taken;
      logic gen_en;
      logic gen_en_d;
      logic [1:0] shape;
      logic [2:0] hs_en;
      logic [2:0] ls_en;
      logic [CNT_W-1:0] period;
      logic [2:0][CNT_W-1:0] duty;
      logic [DEAD_W-1:0] dead;
      logic [CNT_W-1:0] cnt;
      logic cnt_up;
      logic [2:0] hs_q;
      logic [2:0] ls_q;
      logic [2:0][DEAD_W-1:0] dt_cnt;
      logic [2:0] out;
      logic [2:0] oe;
      logic sync;
   } tpwm_state_t;

   tpwm_state_t st_r;
   tpwm_state_t st_nxt;
   tpwm_pkg::tpwm_mode_t mode_sel;
   logic [2:0] hs_pwm;
   logic [2:0] ls_pwm;

   // ----------------------------------------------------------------------
   // Mode selection
   // ----------------------------------------------------------------------
   // Strap variant: high strap means three-input; otherwise decode field
   always_comb
   begin
      if (STRAP_VARIANT)
         mode_sel = st_r.strap_mode ? tpwm_pkg::TPWM_M_THREE : tpwm_pkg::TPWM_M_SIX;
      else if (st_r.mode_field == 2'h3)
         mode_sel = tpwm_pkg::TPWM_M_GEN;
      else if (st_r.mode_field == 2'h2)
         mode_sel = tpwm_pkg::TPWM_M_THREE;
      else
         mode_sel = tpwm_pkg::TPWM_M_SIX;
   end

   // ----------------------------------------------------------------------
   // Raw generated PWM per phase
   // ----------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : g_cmp
         // Duty above counter drives high side; disabled holds low
         assign hs_pwm[g] = st_r.gen_en && st_r.hs_en[g] && (st_r.duty[g] > st_r.cnt);
         // Low side is complement of the duty compare, gated by gen_en and its own ls_en
         assign ls_pwm[g] = st_r.gen_en && st_r.ls_en[g] && !(st_r.duty[g] > st_r.cnt);
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb
   begin
      logic wr_go;
      logic [7:0] rd_a;
      wr_go = 1'b0;
      rd_a = 8'h00;
      st_nxt = st_r;
      // Bus write channels: address and data taken in either order
      if (s_axi_awvalid && !st_r.aw_hold)
      begin
         st_nxt.aw_hold = 1'b1;
         st_nxt.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st_r.w_hold)
      begin
         st_nxt.w_hold = 1'b1;
         st_nxt.wdata = s_axi_wdata;
         st_nxt.wstrb = s_axi_wstrb;
      end
      if (st_r.bvalid && s_axi_bready)
         st_nxt.bvalid = 1'b0;
      wr_go = st_r.aw_hold && st_r.w_hold && !st_r.bvalid;
      if (wr_go)
      begin
         st_nxt.aw_hold = 1'b0;
         st_nxt.w_hold = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = tpwm_pkg::TPWM_RESP_OK;
         // Registers are narrow; only lane 0 and 1 matter
         unique case (st_r.awaddr)
            tpwm_pkg::TPWM_MODE_OFS:
               if (st_r.wstrb[0]) st_nxt.mode_field = st_r.wdata[1:0];
            tpwm_pkg::TPWM_GENCTL_OFS:
            begin
               if (st_r.wstrb[0])
               begin
                  st_nxt.gen_en = st_r.wdata[tpwm_pkg::TPWM_GEN_EN_BIT];
                  st_nxt.shape = st_r.wdata[tpwm_pkg::TPWM_SHAPE_LSB +: 2];
                  st_nxt.hs_en = st_r.wdata[tpwm_pkg::TPWM_HS_EN_LSB +: 3];
               end
               if (st_r.wstrb[1]) st_nxt.ls_en = st_r.wdata[tpwm_pkg::TPWM_LS_EN_LSB +: 3];
            end
            tpwm_pkg::TPWM_PERIOD_OFS: st_nxt.period = st_r.wdata[CNT_W-1:0];
            tpwm_pkg::TPWM_DUTYA_OFS: st_nxt.duty[0] = st_r.wdata[CNT_W-1:0];
            tpwm_pkg::TPWM_DUTYB_OFS: st_nxt.duty[1] = st_r.wdata[CNT_W-1:0];
            tpwm_pkg::TPWM_DUTYC_OFS: st_nxt.duty[2] = st_r.wdata[CNT_W-1:0];
            tpwm_pkg::TPWM_DEAD_OFS: st_nxt.dead = st_r.wdata[DEAD_W-1:0];
            default: st_nxt.bresp = tpwm_pkg::TPWM_RESP_SLVERR;
         endcase
      end
      // Read channel: one cycle to answer
      if (st_r.rvalid && s_axi_rready)
         st_nxt.rvalid = 1'b0;
      if (s_axi_arvalid && !st_r.rvalid)
      begin
         rd_a = s_axi_araddr;
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp = tpwm_pkg::TPWM_RESP_OK;
         st_nxt.rdata = 32'h0000_0000;
         unique case (rd_a)
            tpwm_pkg::TPWM_MODE_OFS: st_nxt.rdata[1:0] = st_r.mode_field;
            tpwm_pkg::TPWM_GENCTL_OFS:
            begin
               st_nxt.rdata[tpwm_pkg::TPWM_GEN_EN_BIT] = st_r.gen_en;
               st_nxt.rdata[tpwm_pkg::TPWM_SHAPE_LSB +: 2] = st_r.shape;
               st_nxt.rdata[tpwm_pkg::TPWM_HS_EN_LSB +: 3] = st_r.hs_en;
               st_nxt.rdata[tpwm_pkg::TPWM_LS_EN_LSB +: 3] = st_r.ls_en;
            end
            tpwm_pkg::TPWM_PERIOD_OFS: st_nxt.rdata[CNT_W-1:0] = st_r.period;
            tpwm_pkg::TPWM_DUTYA_OFS: st_nxt.rdata[CNT_W-1:0] = st_r.duty[0];
            tpwm_pkg::TPWM_DUTYB_OFS: st_nxt.rdata[CNT_W-1:0] = st_r.duty[1];
            tpwm_pkg::TPWM_DUTYC_OFS: st_nxt.rdata[CNT_W-1:0] = st_r.duty[2];
            tpwm_pkg::TPWM_DEAD_OFS: st_nxt.rdata[DEAD_W-1:0] = st_r.dead;
            tpwm_pkg::TPWM_STATUS_OFS:
            begin
               st_nxt.rdata[CNT_W-1:0] = st_r.cnt;
               st_nxt.rdata[16] = st_r.cnt_up;
               st_nxt.rdata[17] = st_r.sync;
               st_nxt.rdata[20 +: 3] = st_r.out;
               st_nxt.rdata[24 +: 3] = st_r.oe;
               st_nxt.rdata[28] = st_r.strap_mode;
            end
            default: st_nxt.rresp = tpwm_pkg::TPWM_RESP_SLVERR;
         endcase
      end
      // Strap caught once after reset; re-caught while asleep
      if (!st_r.strap_taken || !sleep_n_in)
      begin
         st_nxt.strap_mode = mode_strap_in;
         st_nxt.strap_taken = 1'b1;
      end
      // Reference counter, clocked by the system clock
      st_nxt.gen_en_d = st_r.gen_en;
      if (!st_r.gen_en || (mode_sel != tpwm_pkg::TPWM_M_GEN))
      begin
         st_nxt.cnt = (st_r.shape == 2'h1) ? '0 : st_r.period;
         st_nxt.cnt_up = (st_r.shape == 2'h1);
      end
      else if (!st_r.gen_en_d)
      begin
         st_nxt.cnt = (st_r.shape == 2'h1) ? '0 : st_r.period;
         st_nxt.cnt_up = (st_r.shape == 2'h1);
      end
      else
      begin
         unique case (tpwm_pkg::tpwm_shape_t'(st_r.shape))
            tpwm_pkg::TPWM_SH_UPDN:
            begin
               // V shape: down to zero, up to period
               if (st_r.cnt_up)
               begin
                  if (st_r.cnt >= st_r.period)
                  begin
                     st_nxt.cnt_up = 1'b0;
                     st_nxt.cnt = st_r.cnt - 1'b1;
                  end
                  else
                     st_nxt.cnt = st_r.cnt + 1'b1;
               end
               else if (st_r.cnt == '0)
               begin
                  st_nxt.cnt_up = 1'b1;
                  st_nxt.cnt = st_r.cnt + 1'b1;
               end
               else
                  st_nxt.cnt = st_r.cnt - 1'b1;
            end
            tpwm_pkg::TPWM_SH_UP:
               st_nxt.cnt = (st_r.cnt >= st_r.period) ? '0 : st_r.cnt + 1'b1;
            tpwm_pkg::TPWM_SH_DOWN:
               st_nxt.cnt = (st_r.cnt == '0) ? st_r.period : st_r.cnt - 1'b1;
            default: st_nxt.cnt = st_r.cnt;
         endcase
      end
      // Dead time per phase and output drive
      st_nxt.sync = (mode_sel == tpwm_pkg::TPWM_M_GEN) && low_side_cmd_in[1];
      for (int i = 0; i < 3; i++)
      begin
         st_nxt.hs_q[i] = hs_pwm[i];
         st_nxt.ls_q[i] = ls_pwm[i];
         if (hs_pwm[i] != st_r.hs_q[i] || ls_pwm[i] != st_r.ls_q[i])
            st_nxt.dt_cnt[i] = st_r.dead;
         else if (st_r.dt_cnt[i] != '0)
            st_nxt.dt_cnt[i] = st_r.dt_cnt[i] - 1'b1;
         unique case (mode_sel)
            tpwm_pkg::TPWM_M_SIX:
            begin
               st_nxt.oe[i] = high_side_cmd_in[i] ^ low_side_cmd_in[i];
               st_nxt.out[i] = high_side_cmd_in[i];
            end
            tpwm_pkg::TPWM_M_THREE:
            begin
               st_nxt.oe[i] = low_side_cmd_in[i];
               st_nxt.out[i] = high_side_cmd_in[i];
            end
            tpwm_pkg::TPWM_M_GEN:
            begin
               // Switches turn on only once the dead interval has run out
               if (st_nxt.dt_cnt[i] != '0 || (hs_pwm[i] && ls_pwm[i]))
               begin
                  st_nxt.oe[i] = 1'b0;
                  st_nxt.out[i] = 1'b0;
               end
               else
               begin
                  st_nxt.oe[i] = hs_pwm[i] | ls_pwm[i];
                  st_nxt.out[i] = hs_pwm[i];
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         st_r <= '0;
         st_r.mode_field <= tpwm_pkg::TPWM_MODE_RST;
         st_r.period <= tpwm_pkg::TPWM_PERIOD_RST;
         st_r.cnt <= tpwm_pkg::TPWM_PERIOD_RST;
         st_r.dead <= tpwm_pkg::TPWM_DEAD_RST;
      end
      else
         st_r <= st_nxt;
   end

   // Outputs straight from flops
   assign s_axi_awready = !st_r.aw_hold;
   assign s_axi_wready = !st_r.w_hold;
   assign s_axi_bvalid = st_r.bvalid;
   assign s_axi_bresp = st_r.bresp;
   assign s_axi_arready = !st_r.rvalid;
   assign s_axi_rvalid = st_r.rvalid;
   assign s_axi_rdata = st_r.rdata;
   assign s_axi_rresp = st_r.rresp;
   assign phase_out = st_r.out;
   assign phase_oe = st_r.oe;
   assign sync_ref_out = st_r.sync;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   sequence s_gen_on;
      mode_sel == tpwm_pkg::TPWM_M_GEN && st_r.gen_en;
   endsequence

   a_six_hiz: assert property (@(posedge ref_clk) disable iff (rst)
      (mode_sel == tpwm_pkg::TPWM_M_SIX && $stable(mode_sel) && !$rose(rst))
      |=> (phase_oe == $past(high_side_cmd_in ^ low_side_cmd_in)))
      else $error("six-input enable mismatch");
   a_three_follow: assert property (@(posedge ref_clk) disable iff (rst)
      (mode_sel == tpwm_pkg::TPWM_M_THREE ##1 mode_sel == tpwm_pkg::TPWM_M_THREE)
      |-> (phase_oe == $past(low_side_cmd_in)) && (phase_out == $past(high_side_cmd_in)))
      else $error("three-input decode mismatch");
   a_mode_decode: assert property (@(posedge ref_clk) disable iff (rst)
      (!STRAP_VARIANT && st_r.mode_field == 2'h1) |-> mode_sel == tpwm_pkg::TPWM_M_SIX)
      else $error("mode 01b not six-input");
   a_sync_take: assert property (@(posedge ref_clk) disable iff (rst)
      (mode_sel == tpwm_pkg::TPWM_M_GEN && $stable(mode_sel)) |=>
      sync_ref_out == $past(low_side_cmd_in[1]))
      else $error("sync not from phase B low input");
   a_up_wrap: assert property (@(posedge ref_clk) disable iff (rst)
      (s_gen_on and (st_r.gen_en_d && st_r.shape == 2'h1 && st_r.cnt == st_r.period))
      |=> st_r.cnt == '0)
      else $error("up counter did not wrap");
   a_down_reload: assert property (@(posedge ref_clk) disable iff (rst)
      (s_gen_on and (st_r.gen_en_d && st_r.shape == 2'h2 && st_r.cnt == '0))
      |=> st_r.cnt == $past(st_r.period))
      else $error("down counter did not reload");
   a_updn_turn: assert property (@(posedge ref_clk) disable iff (rst)
      (s_gen_on and (st_r.gen_en_d && st_r.shape == 2'h0 && !st_r.cnt_up && st_r.cnt == '0))
      |=> st_r.cnt_up && st_r.cnt == 1)
      else $error("up/down counter did not turn");
   a_restart: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(st_r.gen_en) |=> (st_r.cnt == ((st_r.shape == 2'h1) ? '0 : st_r.period)))
      else $error("counter not restarted");
   a_gen_off: assert property (@(posedge ref_clk) disable iff (rst)
      (mode_sel == tpwm_pkg::TPWM_M_GEN && !st_r.gen_en) |=> (phase_oe & phase_out) == 3'h0)
      else $error("high side active while disabled");
   a_dead_gap: assert property (@(posedge ref_clk) disable iff (rst)
      (mode_sel == tpwm_pkg::TPWM_M_GEN && st_r.dead != '0 && $fell(st_r.ls_q[0])
       && st_r.hs_q[0]) |-> !phase_oe[0])
      else $error("no dead time before high-side on");
endmodule // tpwm_ctrl
`default_nettype wire

// *** tb/tpwm_mcu_model.sv ***
// Controller-side pin model: drives the phase command inputs of the block.
// Assumes the bench calls its tasks from one process after reset.
`timescale 1ns/1ps
`default_nettype none
module tpwm_mcu_model (
   input wire logic ref_clk,
   output logic [2:0] high_cmd,
   output logic [2:0] low_cmd
);
   // Idle levels at time zero
   initial
   begin
      high_cmd = 3'h0;
      low_cmd = 3'h0;
   end
   // One set of command levels, changed just after the edge
   task automatic drive(input logic [2:0] h, input logic [2:0] l);
      @(posedge ref_clk);
      high_cmd <= h;
      low_cmd <= l;
   endtask
   // All commands low before a mode rewrite
   task automatic quiet();
      drive(3'h0, 3'h0);
   endtask
   // Three-input use with no Hi-Z: low-side commands held high
   task automatic no_hiz(input logic [2:0] h);
      drive(h, 3'h7);
   endtask
endmodule // tpwm_mcu_model
`default_nettype wire

// *** tb/three_phase_pwm_control_tb.sv ***
// Self-checking bench for the three-phase PWM control block.
// Assumes 100 MHz ref_clk, AXI4-Lite master tasks, pin model on command inputs.
`timescale 1ns/1ps
`default_nettype none
module three_phase_pwm_control_tb;
   logic ref_clk, rst, awvalid, wvalid, bready, arvalid, rready, slp_n, strap;
   logic awready, wready, bvalid, arready, rvalid, sync_ref;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp;
   logic [2:0] hcmd, lcmd, phase_out, phase_oe;
   logic [15:0] lf;
   int failures, total_checks, cyc, n1, n2;
   localparam logic [1:0] OK = tpwm_pkg::TPWM_RESP_OK;
   localparam logic [1:0] ERR = tpwm_pkg::TPWM_RESP_SLVERR;
   localparam int P = 10;
   localparam int DT = 3;

   tpwm_ctrl u_tpwm_ctrl (.ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .high_side_cmd_in(hcmd), .low_side_cmd_in(lcmd),
      .sleep_n_in(slp_n), .mode_strap_in(strap), .phase_out(phase_out),
      .phase_oe(phase_oe), .sync_ref_out(sync_ref));
   tpwm_mcu_model u_tpwm_mcu_model (.ref_clk(ref_clk), .high_cmd(hcmd), .low_cmd(lcmd));

   // -----------------------------------------------------------------
   // Checking and closing
   // -----------------------------------------------------------------
   task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_pin(input logic [6:0] got, input logic [6:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] t=%0t pins got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks=%0d failures=%0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   function automatic logic [15:0] lfsr_next(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction

   // -----------------------------------------------------------------
   // AXI4-Lite master
   // -----------------------------------------------------------------
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw_p, w_p;
      aw_p = 1'b1;
      w_p = 1'b1;
      @(posedge ref_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever
      begin
         @(posedge ref_clk);
         if (aw_p && awready)
         begin
            aw_p = 1'b0;
            awvalid <= 1'b0;
         end
         if (w_p && wready)
         begin
            w_p = 1'b0;
            wvalid <= 1'b0;
         end
         if (bvalid)
         begin
            bready <= 1'b0;
            chk_bus({30'h0, bresp}, {30'h0, er});
            break;
         end
      end
   endtask
   task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge ref_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever
      begin
         @(posedge ref_clk);
         if (arready && arvalid)
            arvalid <= 1'b0;
         if (rvalid)
         begin
            rready <= 1'b0;
            chk_bus(rdata, ed);
            chk_bus({30'h0, rresp}, {30'h0, er});
            break;
         end
      end
   endtask

   // -----------------------------------------------------------------
   // Generator helpers
   // -----------------------------------------------------------------
   // Cycles until phase A high-side (sel 0) or its enable (sel 1) equals want
   task automatic wait_for(input int sel, input logic want, output int n);
      n = 0;
      do
      begin
         @(posedge ref_clk);
         n++;
      end while (((sel == 0 ? phase_oe[0] & phase_out[0] : phase_oe[0]) !== want) && n < 200);
   endtask
   task automatic gen_setup(input logic [1:0] shape, input logic [11:0] duty, input logic ls);
      axi_write(tpwm_pkg::TPWM_GENCTL_OFS, 32'h0, OK);
      axi_write(tpwm_pkg::TPWM_DUTYA_OFS, {20'h0, duty}, OK);
      axi_write(tpwm_pkg::TPWM_DUTYB_OFS, {20'h0, duty}, OK);
      axi_read(tpwm_pkg::TPWM_DUTYB_OFS, {20'h0, duty}, OK);
      axi_write(tpwm_pkg::TPWM_GENCTL_OFS, {23'h0, ls, 5'h2, shape, 1'b1}, OK);
   endtask

   // Clock and watchdog
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial
   begin
      cyc = 0;
      forever
      begin
         @(posedge ref_clk);
         cyc++;
         if (cyc == 20000)
         begin
            failures++;
            give_verdict();
         end
      end
   end

   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial
   begin
      logic eoe;
      rst = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready, strap} = 6'h0;
      slp_n = 1'b1;
      {awaddr, araddr, wdata} = 48'h0;
      lf = 16'h6722;
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (4) @(posedge ref_clk);
      axi_read(tpwm_pkg::TPWM_PERIOD_OFS, {20'h0, tpwm_pkg::TPWM_PERIOD_RST}, OK);
      axi_read(tpwm_pkg::TPWM_DEAD_OFS, {24'h0, tpwm_pkg::TPWM_DEAD_RST}, OK);
      axi_read(8'h40, 32'h0, ERR);
      axi_write(8'h40, 32'h3, ERR);
      axi_read(tpwm_pkg::TPWM_STATUS_OFS, {20'h0, tpwm_pkg::TPWM_PERIOD_RST}, OK);
      // Strap changed only while asleep, then seen in status
      slp_n <= 1'b0;
      strap <= 1'b1;
      @(posedge ref_clk);
      slp_n <= 1'b1;
      axi_read(tpwm_pkg::TPWM_STATUS_OFS, {4'h1, 16'h0, tpwm_pkg::TPWM_PERIOD_RST}, OK);
      // Six-input (00b, 01b) and three-input (10b) decode with random commands
      for (int m = 0; m < 3; m++)
      begin
         u_tpwm_mcu_model.quiet();
         axi_write(tpwm_pkg::TPWM_MODE_OFS, m, OK);
         axi_read(tpwm_pkg::TPWM_MODE_OFS, m, OK);
         for (int i = 0; i < 13; i++)
         begin
            lf = lfsr_next(lf);
            if (i == 12 && m == 2)
               u_tpwm_mcu_model.no_hiz(lf[2:0]);
            else
               u_tpwm_mcu_model.drive(lf[2:0], lf[5:3]);
            repeat (2) @(posedge ref_clk);
            for (int p = 0; p < 3; p++)
            begin
               eoe = (m == 2) ? lcmd[p] : hcmd[p] ^ lcmd[p];
               chk_pin({4'h0, sync_ref, phase_oe[p], phase_out[p] & phase_oe[p]},
                  {5'h0, eoe, hcmd[p] & eoe});
            end
         end
      end
      // Generation mode: counter shapes give the rising-edge spacing
      u_tpwm_mcu_model.quiet();
      axi_write(tpwm_pkg::TPWM_MODE_OFS, 32'h3, OK);
      axi_write(tpwm_pkg::TPWM_PERIOD_OFS, P, OK);
      axi_write(tpwm_pkg::TPWM_DEAD_OFS, DT, OK);
      for (int s = 0; s < 3; s++)
      begin
         gen_setup(s[1:0], 12'h4, 1'b0);
         // Skip the pulse that overlaps the restart cycle
         wait_for(0, 1'b0, n1);
         wait_for(0, 1'b1, n1);
         wait_for(0, 1'b0, n1);
         wait_for(0, 1'b1, n2);
         chk_bus(n1 + n2, (s == 0) ? 2 * P : P + 1);
      end
      // Dead gap after high side off, then low side on
      gen_setup(2'h1, 12'h4, 1'b1);
      wait_for(0, 1'b1, n1);
      wait_for(1, 1'b0, n1);
      wait_for(1, 1'b1, n2);
      chk_bus(n2, DT);
      chk_pin({6'h0, phase_out[0]}, 7'h0);
      // Duty above period: high side never drops; phase B high side disabled
      gen_setup(2'h1, 12'(P + 1), 1'b0);
      repeat (30) @(posedge ref_clk);
      n1 = 0;
      repeat (25)
      begin
         @(posedge ref_clk);
         if ((phase_oe[0] & phase_out[0]) !== 1'b1 || phase_oe[1] !== 1'b0)
            n1++;
      end
      chk_bus(n1, 0);
      // Disabled generator holds high side off; sync copies phase B low input
      axi_write(tpwm_pkg::TPWM_GENCTL_OFS, 32'h70, OK);
      for (int k = 0; k < 4; k++)
      begin
         lf = lfsr_next(lf);
         u_tpwm_mcu_model.drive(lf[2:0], {lf[4], k[0], lf[3]});
         repeat (2) @(posedge ref_clk);
         chk_pin({sync_ref, phase_oe, phase_out & phase_oe}, {k[0], 6'h0});
      end
      give_verdict();
   end
endmodule // three_phase_pwm_control_tb
`default_nettype wire
